// [cit_pkg.sv]
// Constants shared by the conditional-instruction trace packet encoder
package cit_pkg;

	// ==========================================================
	// Packet encodings
	localparam int        KEY_W        = 14;
	localparam int        KEY_LO_BITS  = 7;
	localparam logic [7:0] HDR_SINGLE  = 8'h6C;
	localparam logic [7:0] HDR_RUN     = 8'h6D;
	localparam logic [7:0] HDR_COMPACT = 8'h40;
	localparam logic [7:0] HDR_FLUSH   = 8'h43;
	localparam int        CONT_BIT     = 7;
	localparam int        SHOULD_BE_ZERO_BIT = 7;
	localparam int        FINAL_BIT    = 6;
	localparam logic [1:0] CODE_INC    = 2'h0;
	localparam logic [1:0] CODE_SAME   = 2'h1;
	localparam logic [1:0] CODE_TWO    = 2'h2;
	localparam logic [1:0] CODE_FLUSH  = 2'h3;

	// ==========================================================
	// Request kinds
	localparam logic [1:0] KIND_SINGLE  = 2'h0;
	localparam logic [1:0] KIND_COMPACT = 2'h1;
	localparam logic [1:0] KIND_RUN     = 2'h2;
	localparam logic [1:0] KIND_FLUSH   = 2'h3;

	// ==========================================================
	// Register map and reset values
	localparam logic [7:0] ADR_CTRL    = 8'h00;
	localparam logic [7:0] ADR_NKEYS   = 8'h04;
	localparam logic [7:0] ADR_IKEYS   = 8'h08;
	localparam logic [7:0] ADR_STATUS  = 8'h0C;
	localparam logic [7:0] ADR_DROPS   = 8'h10;
	localparam logic [KEY_W-1:0] RST_NKEYS     = 14'h0020;
	localparam logic [KEY_W-1:0] RST_IKEYS     = 14'h0020;
	localparam logic [KEY_W-1:0] ONE_BYTE_KEYS = 14'h0080;
	localparam int        STAT_VALID_BIT = 16;
	localparam int        STAT_STEP_BIT  = 17;

endpackage

// [cit_key_step.sv]
// Wrapping key increment and special-key classification
`timescale 1ns/100ps
module cit_key_step (
	input  wire logic [cit_pkg::KEY_W-1:0] key_in,     // Current key
	input  wire logic [cit_pkg::KEY_W-1:0] nkeys_in,   // Normal-key count
	output logic      [cit_pkg::KEY_W-1:0] next_out,   // Key plus one, wrapped
	output logic                           special_out // Key is special
);

	logic [cit_pkg::KEY_W:0] sum;

	assign sum = {1'b0, key_in} + {{cit_pkg::KEY_W{1'b0}}, 1'b1};
	// Any result at or past the normal range restarts at zero
	assign next_out = (sum >= {1'b0, nkeys_in}) ? '0
		: sum[cit_pkg::KEY_W-1:0];
	assign special_out = (key_in >= nkeys_in);

endmodule // cit_key_step

// [cit_encoder.sv]
// Conditional-instruction trace packet encoder with Wishbone registers
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
module cit_encoder (
	input  wire logic                      ref_clk_in,     // 10 MHz clock
	input  wire logic                      rst_in,         // Async reset
	input  wire logic                      wb_cyc_in,      // Bus cycle
	input  wire logic                      wb_stb_in,      // Bus strobe
	input  wire logic                      wb_we_in,       // Write enable
	input  wire logic [7:0]                wb_adr_in,      // Byte address
	input  wire logic [3:0]                wb_sel_in,      // Byte lanes
	input  wire logic [31:0]               wb_dat_in,      // Write data
	output logic      [31:0]               wb_dat_out,     // Read data
	output logic                           wb_ack_out,     // Acknowledge
	input  wire logic                      req_valid_in,   // Element request
	input  wire logic [1:0]                req_kind_in,    // Request kind
	input  wire logic [cit_pkg::KEY_W-1:0] req_key_in,     // Explicit key
	input  wire logic [1:0]                element_count_code_in, // Compact
	input  wire logic [5:0]                req_count_in,   // Run count
	input  wire logic                      req_final_in,   // Repeat flag
	output logic                           req_ready_out,  // Request taken
	output logic      [7:0]                byte_out,       // Stream byte
	output logic                           byte_valid_out, // Byte present
	input  wire logic                      byte_ready_in   // Sink takes byte
);

	// ==========================================================
	// Registers and internal state
	logic                      enable_q;
	logic [cit_pkg::KEY_W-1:0] nkeys_q;
	logic [cit_pkg::KEY_W-1:0] implemented_key_count_q;
	logic [15:0]               drops_q;
	logic [cit_pkg::KEY_W-1:0] last_key_q;
	logic [5:0]                steps_q;
	logic [7:0]                pay_q [0:1];
	logic [1:0]                left_q;
	logic                      idx_q;
	logic                      ack_q;
	logic [31:0]               dat_q;
	logic                      ready_q;
	logic [7:0]                byte_q;
	logic                      valid_q;

	logic                      accept;
	logic                      reserved;
	logic                      wide_keys;
	logic [7:0]                hdr_d;
	logic [7:0]                p0_d;
	logic [7:0]                p1_d;
	logic [1:0]                n_d;
	logic [cit_pkg::KEY_W-1:0] key_next;
	logic                      key_special;
	logic                      req_special;
	logic                      bus_req;
	logic                      bus_wr;

	assign accept   = ready_q & req_valid_in;
	assign reserved = (req_kind_in == cit_pkg::KIND_RUN)
		&& (req_count_in == 6'h00) && !req_final_in;
	assign wide_keys = (implemented_key_count_q > cit_pkg::ONE_BYTE_KEYS);
	assign req_special = (req_key_in >= nkeys_q);
	assign bus_req  = wb_cyc_in & wb_stb_in;
	assign bus_wr   = bus_req & wb_we_in & ack_q;

	cit_key_step u_step (
		.key_in      (last_key_q),
		.nkeys_in    (nkeys_q),
		.next_out    (key_next),
		.special_out (key_special)
	);

	// ==========================================================
	// Packet assembly
	always_comb begin
		hdr_d = cit_pkg::HDR_FLUSH;
		p0_d  = 8'h00;
		p1_d  = 8'h00;
		n_d   = 2'h0;
		case (req_kind_in)
			cit_pkg::KIND_SINGLE: begin
				hdr_d = cit_pkg::HDR_SINGLE;
				// Upper key byte only when the key space needs it
				p0_d  = {wide_keys,
					req_key_in[cit_pkg::KEY_LO_BITS-1:0]};
				p1_d  = {1'b0, req_key_in[cit_pkg::KEY_W-1:cit_pkg::KEY_LO_BITS]};
				n_d   = wide_keys ? 2'h2 : 2'h1;
			end
			cit_pkg::KIND_COMPACT: begin
				hdr_d = cit_pkg::HDR_COMPACT
					| {6'h00, element_count_code_in};
			end
			cit_pkg::KIND_RUN: begin
				hdr_d = cit_pkg::HDR_RUN;
				p0_d  = {1'b0, req_final_in, req_count_in};
				n_d   = 2'h1;
			end
			cit_pkg::KIND_FLUSH: begin
				hdr_d = cit_pkg::HDR_FLUSH;
			end
			default: begin
				hdr_d = cit_pkg::HDR_FLUSH;
			end
		endcase
	end

	// ==========================================================
	// Byte stream output
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			byte_q   <= 8'h00;
			valid_q  <= 1'b0;
			pay_q[0] <= 8'h00;
			pay_q[1] <= 8'h00;
			left_q   <= 2'h0;
			idx_q    <= 1'b0;
		end else if (accept && !reserved) begin
			byte_q   <= hdr_d;
			valid_q  <= 1'b1;
			pay_q[0] <= p0_d;
			pay_q[1] <= p1_d;
			left_q   <= n_d;
			idx_q    <= 1'b0;
		end else if (valid_q && byte_ready_in) begin
			if (left_q != 2'h0) begin
				byte_q <= pay_q[idx_q];
				idx_q  <= 1'b1;
				left_q <= left_q - 2'h1;
			end else begin
				valid_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Running last key, mirroring the analyzer
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			last_key_q <= '0;
			steps_q    <= 6'h00;
		end else if (accept && !reserved) begin
			case (req_kind_in)
				cit_pkg::KIND_SINGLE: begin
					last_key_q <= req_special ? key_next : req_key_in;
				end
				cit_pkg::KIND_COMPACT: begin
					if (element_count_code_in == cit_pkg::CODE_INC
						|| element_count_code_in == cit_pkg::CODE_TWO) begin
						last_key_q <= key_next;
					end
				end
				cit_pkg::KIND_RUN: begin
					steps_q <= req_count_in;
				end
				default: begin
					last_key_q <= last_key_q;
				end
			endcase
		end else if (steps_q != 6'h00) begin
			// One increment per cycle keeps the wrap logic small
			last_key_q <= key_next;
			steps_q    <= steps_q - 6'h01;
		end
	end

	// ==========================================================
	// Request handshake
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= enable_q && !accept && !valid_q && (steps_q == 6'h00);
		end
	end

	// ==========================================================
	// Wishbone slave
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= bus_req & ~ack_q;
			if (bus_req && !ack_q) begin
				case (wb_adr_in)
					cit_pkg::ADR_CTRL:   dat_q <= {31'h0, enable_q};
					cit_pkg::ADR_NKEYS:  dat_q <= {18'h0, nkeys_q};
					cit_pkg::ADR_IKEYS:  dat_q <= {18'h0, implemented_key_count_q};
					cit_pkg::ADR_STATUS: begin
						dat_q <= {14'h0, (steps_q != 6'h00), valid_q, 2'h0, last_key_q};
					end
					cit_pkg::ADR_DROPS:  dat_q <= {16'h0, drops_q};
					default:             dat_q <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			enable_q                <= 1'b0;
			nkeys_q                 <= cit_pkg::RST_NKEYS;
			implemented_key_count_q <= cit_pkg::RST_IKEYS;
		end else if (bus_wr) begin
			if (wb_adr_in == cit_pkg::ADR_CTRL && wb_sel_in[0]) begin
				enable_q <= wb_dat_in[0];
			end
			if (wb_adr_in == cit_pkg::ADR_NKEYS) begin
				if (wb_sel_in[0]) nkeys_q[7:0] <= wb_dat_in[7:0];
				if (wb_sel_in[1]) nkeys_q[13:8] <= wb_dat_in[13:8];
			end
			if (wb_adr_in == cit_pkg::ADR_IKEYS) begin
				if (wb_sel_in[0]) implemented_key_count_q[7:0] <= wb_dat_in[7:0];
				if (wb_sel_in[1]) begin
					implemented_key_count_q[13:8] <= wb_dat_in[13:8];
				end
			end
		end
	end

	// Dropped reserved run requests; a drop in the same cycle as a clearing write leaves the count at one
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			drops_q <= 16'h0000;
		end else if (accept && reserved) begin
			drops_q <= (bus_wr && wb_adr_in == cit_pkg::ADR_DROPS)
				? 16'h0001 : drops_q + 16'h0001;
		end else if (bus_wr && wb_adr_in == cit_pkg::ADR_DROPS) begin
			drops_q <= 16'h0000;
		end
	end

	assign wb_dat_out     = dat_q;
	assign wb_ack_out     = ack_q;
	assign req_ready_out  = ready_q;
	assign byte_out       = byte_q;
	assign byte_valid_out = valid_q;

	// ==========================================================
	// Assertions
	flush_header_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		accept && req_kind_in == cit_pkg::KIND_FLUSH
		|=> valid_q && byte_q == 8'h43 && left_q == 2'h0)
		else $error("flush packet header wrong");

	code_flush_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		accept && req_kind_in == cit_pkg::KIND_COMPACT
		&& element_count_code_in == 2'h3 |=> byte_q == 8'h43 && $stable(last_key_q))
		else $error("all-ones code not sent as flush");

	reserved_drop_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		accept && reserved && !valid_q |=> !valid_q ##1 !valid_q)
		else $error("reserved run payload was sent");

	run_packet_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		accept && req_kind_in == cit_pkg::KIND_RUN && !reserved
		|=> byte_q == 8'h6D && left_q == 2'h1
		&& pay_q[0][7] == 1'b0 && pay_q[0][5:0] == $past(req_count_in)
		&& pay_q[0][6] == $past(req_final_in))
		else $error("run packet layout wrong");

	key_bytes_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		accept && req_kind_in == cit_pkg::KIND_SINGLE
		|=> byte_q == 8'h6C && pay_q[0][7] == (left_q == 2'h2)
		&& left_q == (implemented_key_count_q > 14'h0080 ? 2'h2 : 2'h1))
		else $error("key byte count or continuation wrong");

	code_inc_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		accept && req_kind_in == cit_pkg::KIND_COMPACT
		&& element_count_code_in == 2'h0 && last_key_q < nkeys_q
		|=> last_key_q == (($past(last_key_q) + 14'h0001 == nkeys_q)
		? 14'h0000 : $past(last_key_q) + 14'h0001))
		else $error("compact increment key wrong");

	code_same_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		accept && req_kind_in == cit_pkg::KIND_COMPACT
		&& element_count_code_in == 2'h1
		|=> $stable(last_key_q) && byte_q == 8'h41)
		else $error("compact reuse changed key");

	run_steps_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		accept && req_kind_in == cit_pkg::KIND_RUN && req_count_in == 6'h02
		|=> steps_q == 6'h02 ##1 steps_q == 6'h01 ##1 steps_q == 6'h00)
		else $error("run key stepping wrong");

	bus_ack_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ack_q |=> !ack_q)
		else $error("ack held longer than one cycle");

endmodule // cit_encoder

// [cit_trace_analyzer.sv]
// Trace analyzer model that takes and decodes the conditional packet stream
`timescale 1ns/100ps
module cit_trace_analyzer (
	input  wire logic                      clk_in,      // Stream clock
	input  wire logic                      rst_in,      // Async reset
	input  wire logic [7:0]                byte_in,     // Stream byte
	input  wire logic                      valid_in,    // Byte present
	input  wire logic [cit_pkg::KEY_W-1:0] nkeys_in,    // Normal-key count
	output logic                           ready_out,   // Byte taken
	output logic      [cit_pkg::KEY_W-1:0] last_key_out, // Rebuilt last key
	output logic      [31:0]               pend_out      // Pending C elements
);
	// ==========================================================
	// Decoder state
	logic [1:0]  st_q;
	logic [13:0] acc_q;
	logic [3:0]  sh_q;
	int          pend_q;

	assign pend_out = pend_q;

	function automatic logic [13:0] inc(input logic [13:0] k,
		input logic [13:0] n);
		return (k + 14'h0001 >= n) ? 14'h0000 : k + 14'h0001;
	endfunction

	always_ff @(posedge clk_in or posedge rst_in) begin : dec
		logic [13:0] k;
		logic [13:0] full;
		if (rst_in) begin
			st_q <= 2'h0;
			acc_q <= 14'h0000;
			sh_q <= 4'h0;
			pend_q <= 0;
			ready_out <= 1'b0;
			last_key_out <= 14'h0000;
		end else begin
			// Sink stalls at random, as a real one may
			ready_out <= ($urandom_range(3) != 0);
			k = last_key_out;
			full = acc_q | ({7'h00, byte_in[6:0]} << sh_q);
			if (valid_in && ready_out) begin
				case (st_q)
				2'h0: begin
					if (byte_in == 8'h6C) begin
						st_q <= 2'h1;
						acc_q <= 14'h0000;
						sh_q <= 4'h0;
					end else if (byte_in == 8'h6D) begin
						st_q <= 2'h2;
					end else if (byte_in == 8'h43) begin
						pend_q <= 0;
					end else if (byte_in[7:2] == 6'h10) begin
						if (byte_in[1:0] != 2'h1)
							k = inc(k, nkeys_in);
						pend_q <= pend_q + ((byte_in[1:0] == 2'h2) ? 2 : 1);
					end
				end
				2'h1: begin
					if (byte_in[7]) begin
						acc_q <= full;
						sh_q <= sh_q + 4'h7;
					end else begin
						k = (full >= nkeys_in) ? inc(k, nkeys_in) : full;
						pend_q <= pend_q + 1;
						st_q <= 2'h0;
					end
				end
				default: begin
					for (int i = 0; i < int'(byte_in[5:0]); i++)
						k = inc(k, nkeys_in);
					pend_q <= pend_q + int'(byte_in[5:0]) + int'(byte_in[6]);
					st_q <= 2'h0;
				end
				endcase
			end
			last_key_out <= k;
		end
	end
endmodule // cit_trace_analyzer

// [cit_encoder_bench.sv]
// Self-checking bench for the conditional packet encoder
`timescale 1ns/100ps
module cit_encoder_bench;
	// ==========================================================
	// Signals and model state
	logic        ref_clk_in;
	logic        rst_in;
	logic        wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
	logic [7:0]  wb_adr_in, byte_out;
	logic [3:0]  wb_sel_in;
	logic [31:0] wb_dat_in, wb_dat_out;
	logic        req_valid_in, req_ready_out, req_final_in;
	logic [1:0]  req_kind_in, element_count_code_in;
	logic [13:0] req_key_in, part_key, mk, nk, ik;
	logic [5:0]  req_count_in;
	logic        byte_valid_out, byte_ready_in;
	logic [7:0]  bq[$];
	logic [31:0] rq[$];
	logic [31:0] part_pend;
	int          err_count, check_count, drops, pc;

	cit_encoder cit_encoder_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
		.wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.req_valid_in(req_valid_in), .req_kind_in(req_kind_in),
		.req_key_in(req_key_in), .element_count_code_in(element_count_code_in),
		.req_count_in(req_count_in), .req_final_in(req_final_in),
		.req_ready_out(req_ready_out), .byte_out(byte_out),
		.byte_valid_out(byte_valid_out), .byte_ready_in(byte_ready_in));
	cit_trace_analyzer cit_trace_analyzer_i (.clk_in(ref_clk_in),
		.rst_in(rst_in), .byte_in(byte_out), .valid_in(byte_valid_out),
		.nkeys_in(nk), .ready_out(byte_ready_in), .last_key_out(part_key),
		.pend_out(part_pend));

	// ==========================================================
	// Checking
	task automatic summarize();
		if (err_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic bad(input string m);
		err_count++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) bad($sformatf("byte %h expected %h", g, e));
	endtask
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) bad($sformatf("word %h expected %h", g, e));
	endtask
	always @(posedge ref_clk_in) begin
		if (byte_valid_out === 1'b1 && byte_ready_in === 1'b1) begin
			if (bq.size() == 0) bad("unexpected byte");
			else chk_byte(byte_out, bq.pop_front());
		end
		if (wb_ack_out === 1'b1 && wb_we_in === 1'b0) begin
			if (rq.size() == 0) bad("unexpected read");
			else chk_reg(wb_dat_out, rq.pop_front());
		end
	end

	// ==========================================================
	// Drivers
	function automatic logic [13:0] inc(input logic [13:0] k);
		return (k + 14'h0001 >= nk) ? 14'h0000 : k + 14'h0001;
	endfunction
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (req_ready_out !== 1'b1 && n < 400);
		if (req_ready_out !== 1'b1) begin
			bad("ready timeout");
			summarize();
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 50);
		if (wb_ack_out !== 1'b1) begin
			bad("ack timeout");
			summarize();
		end
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		@(posedge ref_clk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask
	task automatic send(input logic [1:0] kd, input logic [13:0] k,
		input logic [1:0] cd, input logic [5:0] cn, input logic f);
		req_valid_in <= 1'b1;
		req_kind_in <= kd;
		req_key_in <= k;
		element_count_code_in <= cd;
		req_count_in <= cn;
		req_final_in <= f;
		wait_ready();
		req_valid_in <= 1'b0;
		case (kd)
		cit_pkg::KIND_SINGLE: begin
			bq.push_back(8'h6C);
			if (ik > 14'h0080) begin
				bq.push_back({1'b1, k[6:0]});
				bq.push_back({1'b0, k[13:7]});
			end else bq.push_back({1'b0, k[6:0]});
			mk = (k >= nk) ? inc(mk) : k;
			pc++;
		end
		cit_pkg::KIND_COMPACT: begin
			bq.push_back({6'h10, cd});
			if (cd == 2'h0 || cd == 2'h2) mk = inc(mk);
			if (cd == 2'h3) pc = 0;
			else pc += (cd == 2'h2) ? 2 : 1;
		end
		cit_pkg::KIND_RUN: begin
			if (cn == 6'h00 && !f) drops++;
			else begin
				bq.push_back(8'h6D);
				bq.push_back({1'b0, f, cn});
				repeat (cn) mk = inc(mk);
				pc += int'(cn) + int'(f);
			end
		end
		default: begin
			bq.push_back(8'h43);
			pc = 0;
		end
		endcase
		wait_ready();
		rd(cit_pkg::ADR_STATUS, {18'h0, mk});
		chk_reg({18'h0, part_key}, {18'h0, mk});
		chk_reg(part_pend, 32'(pc));
	endtask

	// ==========================================================
	// Sequence
	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		rst_in = 1'b1;
		{wb_cyc_in, wb_stb_in, wb_we_in, req_valid_in} = 4'h0;
		{wb_adr_in, wb_dat_in, req_kind_in, req_key_in} = '0;
		{element_count_code_in, req_count_in, req_final_in} = '0;
		wb_sel_in = 4'hF;
		{mk, nk, ik} = {14'h0000, 14'h0020, 14'h0020};
		{err_count, check_count, drops, pc} = '0;
		void'($urandom(61150));
		repeat (3) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(posedge ref_clk_in);
		rd(cit_pkg::ADR_CTRL, 32'h0);
		rd(cit_pkg::ADR_NKEYS, 32'h20);
		rd(cit_pkg::ADR_IKEYS, 32'h20);
		rd(cit_pkg::ADR_STATUS, 32'h0);
		rd(cit_pkg::ADR_DROPS, 32'h0);
		rd(8'h20, 32'h0);
		wb(1'b1, cit_pkg::ADR_NKEYS, 32'h5);
		nk <= 14'h0005;
		wb(1'b1, cit_pkg::ADR_CTRL, 32'h1);
		rd(cit_pkg::ADR_NKEYS, 32'h5);
		send(cit_pkg::KIND_SINGLE, 14'h0003, 2'h0, 6'h00, 1'b0);
		send(cit_pkg::KIND_SINGLE, 14'h0014, 2'h0, 6'h00, 1'b0);
		for (int c = 0; c < 4; c++)
			send(cit_pkg::KIND_COMPACT, 14'h0, 2'(c), 6'h0, 1'b0);
		send(cit_pkg::KIND_RUN, 14'h0000, 2'h0, 6'h07, 1'b1);
		send(cit_pkg::KIND_RUN, 14'h0000, 2'h0, 6'h02, 1'b0);
		send(cit_pkg::KIND_RUN, 14'h0000, 2'h0, 6'h00, 1'b1);
		send(cit_pkg::KIND_RUN, 14'h0000, 2'h0, 6'h00, 1'b0);
		rd(cit_pkg::ADR_DROPS, 32'h1);
		wb(1'b1, cit_pkg::ADR_DROPS, 32'h0);
		drops = 0;
		send(cit_pkg::KIND_FLUSH, 14'h0000, 2'h0, 6'h00, 1'b0);
		for (int i = 0; i < 30; i++)
			send(2'($urandom_range(3)), 14'($urandom_range(31)),
				2'($urandom_range(3)), 6'($urandom_range(63)),
				1'($urandom_range(1)));
		rd(cit_pkg::ADR_DROPS, 32'(drops));
		wb(1'b1, cit_pkg::ADR_IKEYS, 32'hC8);
		ik = 14'h00C8;
		send(cit_pkg::KIND_SINGLE, 14'h0096, 2'h0, 6'h00, 1'b0);
		summarize();
	end
endmodule // cit_encoder_bench
